// ==== core/flrc_pkg.sv ====
// Purpose: Shared constants, opcodes and helpers for the register command decoder.
// Assumes: Core clock of 100 MHz; serial clock no faster than 108 MHz.
// Notes:   Status and config bit positions follow the volatile register layout.
`default_nettype none
package flrc_pkg;

  localparam logic [7:0] OP_WRITE_ENABLE     = 8'h06;
  localparam logic [7:0] OP_VOL_WRITE_ENABLE = 8'h50;
  localparam logic [7:0] OP_CLEAR_STATUS     = 8'h30;
  localparam logic [7:0] OP_PATTERN_PROGRAM  = 8'h43;
  localparam logic [7:0] OP_PATTERN_WRITE    = 8'h4a;
  localparam logic [7:0] OP_PATTERN_READ     = 8'h41;
  localparam logic [7:0] OP_ENTER_WIDE_ADDR  = 8'hb7;
  localparam logic [7:0] OP_EXIT_WIDE_ADDR   = 8'he9;

  localparam int STATUS1_WIP_BIT      = 0;
  localparam int STATUS1_WEL_BIT      = 1;
  localparam int STATUS2_PROG_ERR_BIT = 5;
  localparam int STATUS2_ERASE_ERR_BIT = 6;
  localparam int CONFIG2_ADDR_LEN_BIT = 0;
  localparam int CONFIG2NV_ADDR_LEN_BIT = 1;

  // Serial clock edge counts: one byte on one line or four lines, the dummy clock, and the count ceiling.
  localparam logic [5:0] EDGES_BYTE_SINGLE = 6'h08;
  localparam logic [5:0] EDGES_BYTE_QUAD   = 6'h02;
  localparam logic [5:0] EDGES_DUMMY       = 6'h01;
  localparam logic [5:0] EDGES_MAX         = 6'h3f;

  localparam logic [7:0] PATTERN_RESET     = 8'h00;
  localparam logic [2:0] ADDR_BYTES_SHORT  = 3'h3;
  localparam logic [2:0] ADDR_BYTES_WIDE   = 3'h4;

  localparam int CLK_MHZ             = 100;
  localparam int PATTERN_PROGRAM_US  = 50;
  localparam int PATTERN_PROGRAM_CYCLES = PATTERN_PROGRAM_US * CLK_MHZ;

  typedef enum {
    PRG_IDLE,
    PRG_BUSY
  } flrc_prog_type;

  // Edges that carry one byte in the current line mode.
  function automatic logic [5:0] byte_edges(input logic quad);
    byte_edges = quad ? EDGES_BYTE_QUAD : EDGES_BYTE_SINGLE;
  endfunction

  // Address length a command expects.
  function automatic logic [2:0] addr_bytes(input logic wideOnly, input logic addrLen);
    addr_bytes = (wideOnly || addrLen) ? ADDR_BYTES_WIDE : ADDR_BYTES_SHORT;
  endfunction

endpackage
`default_nettype wire

// ==== core/flrc_sync.sv ====
// Purpose: Two-flop synchroniser for a single level.
// Assumes: The input comes from another clock domain or a pin.
// Notes:   The first flop feeds only the second.
`default_nettype none
module flrc_sync (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic asyncIn,
  output var  logic syncOut
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = asyncIn;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign syncOut = sync_q;

endmodule
`default_nettype wire

// ==== core/flrc_timer.sv ====
// Purpose: Self-timed cycle counter for the stored pattern program.
// Assumes: start is a one-cycle pulse; a start while running is ignored.
// Notes:   done pulses for one cycle when the count runs out.
`default_nettype none
module flrc_timer #(
  parameter int CYCLES = 16
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic start,
  output var  logic done
);

  logic [15:0] count_q;
  logic [15:0] count_d;
  logic        run_q;
  logic        run_d;
  logic        done_q;
  logic        done_d;

  always_comb begin
    count_d = count_q;
    run_d   = run_q;
    done_d  = 1'b0;
    if (!run_q && start) begin
      run_d   = 1'b1;
      count_d = 16'(CYCLES - 1);
    end else if (run_q) begin
      if (count_q == 16'h0000) begin
        run_d  = 1'b0;
        done_d = 1'b1;
      end else begin
        count_d = count_q - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 16'h0000;
      run_q   <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      run_q   <= run_d;
      done_q  <= done_d;
    end
  end

  assign done = done_q;

endmodule
`default_nettype wire

// ==== core/flrc_decoder.sv ====
// Purpose: Serial decoder for the register control commands of the flash device.
// Assumes: Serial mode 0; serial clock stopped while chip select is high.
// Notes:   The pattern and line mode are read by the link only while they are stable.
`default_nettype none

// Summary of operation
// - Volatile write enable leaves the latch alone, only steers the next register write.
// - After it, a register write updates volatile status and config registers only.
// - Single-byte instructions execute only if chip select rises after bit eight.
// - Clear status zeroes write in progress, latch, program error, erase error.
// - Clear status needs no prior write enable.
// - Clear status is accepted while write in progress is set.
// - Stored pattern program is rejected unless the latch is set.
// - Stored program needs chip select high after data bit eight, then starts.
// - Busy during stored program; at completion the latch clears, and busy clears unless it failed.
// - A failed stored program sets the program error bit.
// - Volatile pattern write is rejected unless the latch is set.
// - Volatile write needs chip select high after data bit eight; applied at once.
// - Pattern read waits one dummy clock then shifts the pattern on line one.
// - The pattern repeats for as long as clocks keep coming.
// - Enter wide address sets the address length bit.
// - Wide-only commands always expect four address bytes.
// - Exit wide address clears the address length bit.
// - Any-register write clears it; resets load it back from the stored setting.
// - In four-line mode instruction and write data travel four bits a clock.
// - In four-line mode the pattern read returns four bits a clock.
// - Write enable sets the latch.
// - A failed register write stays busy until clear status.
module flrc_decoder
  import flrc_pkg::*;
#(
  parameter int PROGRAM_CYCLES = flrc_pkg::PATTERN_PROGRAM_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       serialClk,
  input  wire logic       chipSelectN,
  input  wire logic [3:0] ioIn,
  output var  logic [3:0] ioOut,
  output var  logic [3:0] ioOe,
  input  wire logic       fourLineMode,
  input  wire logic       config2NonvolAddrLen,
  input  wire logic       deviceResetPulse,
  input  wire logic       anyRegWriteClearAddrLen,
  input  wire logic       registerWriteFailPulse,
  input  wire logic       eraseFailPulse,
  input  wire logic       registerWriteDonePulse,
  input  wire logic       nvProgramFail,
  input  wire logic       wideOnlyCommand,
  output var  logic       writeInProgress,
  output var  logic       writeEnableLatch,
  output var  logic       programError,
  output var  logic       eraseError,
  output var  logic       registerWriteToVolatile,
  output var  logic       addressLengthBit,
  output var  logic [2:0] addressBytes,
  output var  logic [7:0] learningPatternVol,
  output var  logic [7:0] learningPatternNonvol
);
  import flrc_pkg::*;

  // Link domain, clocked by the serial clock.
  logic [5:0]  edges_q;
  logic [5:0]  edges_d;
  logic [15:0] shift_q;
  logic [15:0] shift_d;
  logic [5:0]  frameEdges_q;
  logic [5:0]  frameEdges_d;
  logic [7:0]  opcode_q;
  logic [7:0]  opcode_d;
  logic        frameToggle_q;
  logic        frameToggle_d;
  logic [2:0]  phase_q;
  logic [2:0]  phase_d;
  logic [3:0]  ioOut_q;
  logic [3:0]  ioOut_d;
  logic [3:0]  ioOe_q;
  logic [3:0]  ioOe_d;
  logic        linkReset;

  // Core domain.
  logic        csHigh;
  logic        toggleSync;
  logic        csHigh_q;
  logic        seenToggle_q;
  logic        seenToggle_d;
  logic        quad_q;
  logic        wip_q;
  logic        wip_d;
  logic        wel_q;
  logic        wel_d;
  logic        progErr_q;
  logic        progErr_d;
  logic        eraseErr_q;
  logic        eraseErr_d;
  logic        volSteer_q;
  logic        volSteer_d;
  logic        addrLen_q;
  logic        addrLen_d;
  logic        strapLoad_q;
  logic [2:0]  addrBytes_q;
  logic [2:0]  addrBytes_d;
  logic [7:0]  patVol_q;
  logic [7:0]  patVol_d;
  logic [7:0]  patNv_q;
  logic [7:0]  patNv_d;
  logic [7:0]  patPend_q;
  logic [7:0]  patPend_d;
  flrc_prog_type prog_q;
  flrc_prog_type prog_d;
  logic        progStart;
  logic        progDone;
  logic        frameEnd;
  logic [5:0]  shortLen;
  logic [7:0]  shortOp;
  logic [7:0]  longOp;
  logic [7:0]  dataByte;

  assign linkReset = chipSelectN || !reset_n;

  // Instruction and data capture on rising serial clock edges.
  always_comb begin
    edges_d       = (edges_q == EDGES_MAX) ? edges_q : edges_q + 6'h01;
    shift_d       = quad_q ? {shift_q[11:0], ioIn} : {shift_q[14:0], ioIn[0]};
    frameEdges_d  = edges_d;
    opcode_d      = opcode_q;
    frameToggle_d = (edges_q == 6'h00) ? !frameToggle_q : frameToggle_q;
    if (edges_d == byte_edges(quad_q)) begin
      opcode_d = shift_d[7:0];
    end
  end

  always_ff @(posedge serialClk or posedge linkReset) begin
    if (linkReset) begin
      edges_q  <= 6'h00;
      opcode_q <= 8'h00;
    end else begin
      edges_q  <= edges_d;
      opcode_q <= opcode_d;
    end
  end

  // These survive chip select so the core can read them after the frame.
  always_ff @(posedge serialClk or negedge reset_n) begin
    if (!reset_n) begin
      shift_q       <= 16'h0000;
      frameEdges_q  <= 6'h00;
      frameToggle_q <= 1'b0;
    end else begin
      shift_q       <= shift_d;
      frameEdges_q  <= frameEdges_d;
      frameToggle_q <= frameToggle_d;
    end
  end

  // Pattern read output, launched on falling edges after the dummy clock.
  // Lines are still shifted in during the dummy clock, but their level does not matter.
  always_comb begin
    ioOut_d = ioOut_q;
    ioOe_d  = 4'h0;
    phase_d = phase_q;
    if (opcode_q == OP_PATTERN_READ && edges_q >= byte_edges(quad_q) + EDGES_DUMMY) begin
      phase_d = phase_q + 3'h1;
      if (quad_q) begin
        ioOe_d  = 4'hf;
        ioOut_d = phase_q[0] ? patVol_q[3:0] : patVol_q[7:4];
      end else begin
        ioOe_d  = 4'h2;
        ioOut_d = {2'b00, patVol_q[3'h7 - phase_q], 1'b0};
      end
    end
  end

  always_ff @(negedge serialClk or posedge linkReset) begin
    if (linkReset) begin
      ioOut_q <= 4'h0;
      ioOe_q  <= 4'h0;
      phase_q <= 3'h0;
    end else begin
      ioOut_q <= ioOut_d;
      ioOe_q  <= ioOe_d;
      phase_q <= phase_d;
    end
  end

  // Chip select and the frame toggle are levels from the link side.
  flrc_sync u_cs_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn (chipSelectN),
    .syncOut (csHigh)
  );

  flrc_sync u_toggle_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn (frameToggle_q),
    .syncOut (toggleSync)
  );

  flrc_timer #(
    .CYCLES (PROGRAM_CYCLES)
  ) u_prog_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (progStart),
    .done    (progDone)
  );

  // A frame counts only if the serial clock moved in it; a bare select pulse is ignored.
  assign frameEnd = csHigh && !csHigh_q && (toggleSync != seenToggle_q);
  assign shortLen = byte_edges(quad_q);
  assign shortOp  = shift_q[7:0];
  assign longOp   = shift_q[15:8];
  assign dataByte = shift_q[7:0];

  always_comb begin
    wip_d        = wip_q;
    wel_d        = wel_q;
    progErr_d    = progErr_q;
    eraseErr_d   = eraseErr_q;
    volSteer_d   = volSteer_q;
    addrLen_d    = addrLen_q;
    patVol_d     = patVol_q;
    patNv_d      = patNv_q;
    patPend_d    = patPend_q;
    prog_d       = prog_q;
    progStart    = 1'b0;
    seenToggle_d = frameEnd ? toggleSync : seenToggle_q;

    if (strapLoad_q || deviceResetPulse) begin
      addrLen_d = config2NonvolAddrLen;
    end
    if (anyRegWriteClearAddrLen) begin
      addrLen_d = 1'b0;
    end
    if (registerWriteDonePulse) begin
      volSteer_d = 1'b0;
    end

    if (frameEnd && frameEdges_q == shortLen) begin
      case (shortOp)
        OP_CLEAR_STATUS: begin
          wip_d      = 1'b0;
          wel_d      = 1'b0;
          progErr_d  = 1'b0;
          eraseErr_d = 1'b0;
          prog_d     = PRG_IDLE;
        end
        OP_WRITE_ENABLE: begin
          if (!wip_q) begin
            wel_d      = 1'b1;
            volSteer_d = 1'b0;
          end
        end
        OP_VOL_WRITE_ENABLE: begin
          if (!wip_q) begin
            volSteer_d = 1'b1;
          end
        end
        OP_ENTER_WIDE_ADDR: begin
          if (!wip_q) begin
            addrLen_d = 1'b1;
          end
        end
        OP_EXIT_WIDE_ADDR: begin
          if (!wip_q) begin
            addrLen_d = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end else if (frameEnd && frameEdges_q == (shortLen << 1) && wel_q && !wip_q) begin
      case (longOp)
        OP_PATTERN_WRITE: begin
          patVol_d = dataByte;
        end
        OP_PATTERN_PROGRAM: begin
          patPend_d = dataByte;
          wip_d     = 1'b1;
          prog_d    = PRG_BUSY;
          progStart = 1'b1;
        end
        default: begin
        end
      endcase
    end

    if (prog_q == PRG_BUSY && progDone) begin
      prog_d = PRG_IDLE;
      wel_d  = 1'b0;
      if (nvProgramFail) begin
        progErr_d = 1'b1;
      end else begin
        wip_d   = 1'b0;
        patNv_d = patPend_q;
      end
    end

    // Hardware error events are applied last so they win over a clear in the same cycle.
    if (registerWriteFailPulse) begin
      progErr_d = 1'b1;
      wip_d     = 1'b1;
    end
    if (eraseFailPulse) begin
      eraseErr_d = 1'b1;
      wip_d      = 1'b1;
    end
    addrBytes_d = addr_bytes(wideOnlyCommand, addrLen_d);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      csHigh_q     <= 1'b1;
      seenToggle_q <= 1'b0;
      quad_q       <= 1'b0;
      wip_q        <= 1'b0;
      wel_q        <= 1'b0;
      progErr_q    <= 1'b0;
      eraseErr_q   <= 1'b0;
      volSteer_q   <= 1'b0;
      addrLen_q    <= 1'b0;
      strapLoad_q  <= 1'b1;
      addrBytes_q  <= ADDR_BYTES_SHORT;
      patVol_q     <= PATTERN_RESET;
      patNv_q      <= PATTERN_RESET;
      patPend_q    <= PATTERN_RESET;
      prog_q       <= PRG_IDLE;
    end else begin
      csHigh_q     <= csHigh;
      seenToggle_q <= seenToggle_d;
      quad_q       <= fourLineMode;
      wip_q        <= wip_d;
      wel_q        <= wel_d;
      progErr_q    <= progErr_d;
      eraseErr_q   <= eraseErr_d;
      volSteer_q   <= volSteer_d;
      addrLen_q    <= addrLen_d;
      strapLoad_q  <= 1'b0;
      addrBytes_q  <= addrBytes_d;
      patVol_q     <= patVol_d;
      patNv_q      <= patNv_d;
      patPend_q    <= patPend_d;
      prog_q       <= prog_d;
    end
  end

  assign ioOut                   = ioOut_q;
  assign ioOe                    = ioOe_q;
  assign writeInProgress         = wip_q;
  assign writeEnableLatch        = wel_q;
  assign programError            = progErr_q;
  assign eraseError              = eraseErr_q;
  assign registerWriteToVolatile = volSteer_q;
  assign addressLengthBit        = addrLen_q;
  assign addressBytes            = addrBytes_q;
  assign learningPatternVol      = patVol_q;
  assign learningPatternNonvol   = patNv_q;

endmodule
`default_nettype wire

// ==== dv/flrc_host_model.sv ====
// Purpose: Host side of the serial link that frames commands for the decoder.
// Assumes: Mode 0 timing; the serial clock only runs inside a frame.
// Notes:   Released lines carry the inverse of their last value.
`default_nettype none
module flrc_host_model (
  output var  logic       serialClk,
  output var  logic       chipSelectN,
  output var  logic [3:0] ioIn,
  input  wire logic [3:0] ioOut,
  input  wire logic [3:0] ioOe,
  input  wire logic       quad
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    serialClk = 1'b0;
    chipSelectN = 1'b1;
    ioIn = 4'h0;
  end

  // A 64 ns period keeps every command well under the serial clock ceiling.
  task automatic frame(input logic [15:0] d, input int nIn, input int nRd,
                       output logic [7:0] rd, output logic [3:0] oe);
    rd = 8'h00;
    oe = 4'h0;
    chipSelectN = 1'b0;
    for (int i = 0; i < nIn + nRd + int'(nRd > 0); i++) begin
      if (i >= nIn)
        ioIn = ~ioIn;
      else if (quad)
        ioIn = d[15 - 4 * i -: 4];
      else
        ioIn = {3'h0, d[15 - i]};
      #16 serialClk = 1'b1;
      if (i > nIn)
        rd = quad ? {rd[3:0], ioOut} : {rd[6:0], ioOut[1]};
      if (i > nIn)
        oe = ioOe;
      #32 serialClk = 1'b0;
      #16;
    end
    chipSelectN = 1'b1;
    ioIn = ~ioIn;
    #60;
  endtask
endmodule
`default_nettype wire

// ==== dv/flrc_decoder_chk.sv ====
// Purpose: Port assertions for the register command decoder.
// Assumes: Bound to flrc_decoder; sampled on the core clock.
// Notes:   Link outputs are watched from the core domain.
`default_nettype none
module flrc_chk (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       chipSelectN,
  input wire logic [3:0] ioOe,
  input wire logic       fourLineMode,
  input wire logic       anyRegWriteClearAddrLen,
  input wire logic       registerWriteFailPulse,
  input wire logic       eraseFailPulse,
  input wire logic       wideOnlyCommand,
  input wire logic       writeInProgress,
  input wire logic       writeEnableLatch,
  input wire logic       programError,
  input wire logic       eraseError,
  input wire logic       addressLengthBit,
  input wire logic [2:0] addressBytes,
  input wire logic [7:0] learningPatternVol,
  input wire logic [7:0] learningPatternNonvol
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_WEL_SET: assert property ($rose(writeEnableLatch) |-> $past(chipSelectN, 2))
    else $error("Latch set inside a frame");
  // An erase failure in the clearing cycle wins, so that cycle is left out.
  AST_CLEAR_ALL: assert property ($fell(programError) && !$past(eraseFailPulse) |->
    !writeInProgress && !writeEnableLatch && !eraseError)
    else $error("Status bits not cleared together");
  AST_ERR_BUSY: assert property ($rose(programError) |-> writeInProgress)
    else $error("Program error without busy");
  AST_PROG_HOLD: assert property ($rose(writeInProgress) && !$past(registerWriteFailPulse)
    && !$past(eraseFailPulse) |-> writeInProgress [*8])
    else $error("Busy dropped early");
  AST_NONVOL_DONE: assert property ($changed(learningPatternNonvol) |->
    !writeInProgress && !writeEnableLatch)
    else $error("Stored pattern changed before completion");
  AST_VOL_WEL: assert property ($changed(learningPatternVol) |->
    writeEnableLatch && $stable(writeEnableLatch))
    else $error("Live pattern written without latch");
  AST_ADDR_BYTES: assert property (addressBytes ==
    (($past(wideOnlyCommand) || addressLengthBit) ? 3'h4 : 3'h3))
    else $error("Address byte count wrong");
  AST_ADDR_CLR: assert property (anyRegWriteClearAddrLen && chipSelectN &&
    $past(chipSelectN, 5) |=> !addressLengthBit)
    else $error("Address length not cleared");
  AST_IDLE_LINES: assert property (chipSelectN && $past(chipSelectN) |-> ioOe == 4'h0)
    else $error("Lines driven while deselected");
  AST_READ_LINES: assert property (!chipSelectN && ioOe != 4'h0 |->
    ioOe == (fourLineMode ? 4'hf : 4'h2))
    else $error("Wrong lines driven");

  cover property ($rose(writeInProgress));
  cover property ($changed(learningPatternVol));
  cover property ($rose(addressLengthBit));
endmodule

bind flrc_decoder flrc_chk flrc_chk_i (
  .clk, .reset_n, .chipSelectN, .ioOe, .fourLineMode, .anyRegWriteClearAddrLen,
  .registerWriteFailPulse, .eraseFailPulse, .wideOnlyCommand, .writeInProgress,
  .writeEnableLatch, .programError, .eraseError, .addressLengthBit, .addressBytes,
  .learningPatternVol, .learningPatternNonvol
);
`default_nettype wire

// ==== dv/tb_top.sv ====
// Purpose: Self-checking bench for the register command decoder.
// Assumes: Program timer shortened to 20 core cycles.
// Notes:   Waits cover the two-flop crossing after each frame.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import flrc_pkg::*;
  logic       clk, reset_n, sck, csN, quad, nvLen, nvFail, wideOnly;
  logic       write_in_progress, write_enable_latch, pErr, eErr, toVol, addrLen;
  logic [3:0] ioIn, ioOut, ioOe, oev;
  logic [4:0] pulseV;
  logic [7:0] rdv, patV, patN;
  logic [2:0] addrBytes;
  wire  logic [3:0] st;
  int         miscompares, samples_checked;
  assign st = {write_in_progress, write_enable_latch, pErr, eErr};

  flrc_decoder #(.PROGRAM_CYCLES(20)) flrc_decoder_i (
    .clk(clk), .reset_n(reset_n), .serialClk(sck), .chipSelectN(csN), .ioIn(ioIn),
    .ioOut(ioOut), .ioOe(ioOe), .fourLineMode(quad), .config2NonvolAddrLen(nvLen),
    .deviceResetPulse(pulseV[0]), .anyRegWriteClearAddrLen(pulseV[1]),
    .registerWriteFailPulse(pulseV[2]), .eraseFailPulse(pulseV[3]),
    .registerWriteDonePulse(pulseV[4]), .nvProgramFail(nvFail), .wideOnlyCommand(wideOnly),
    .writeInProgress(write_in_progress), .writeEnableLatch(write_enable_latch), .programError(pErr), .eraseError(eErr),
    .registerWriteToVolatile(toVol), .addressLengthBit(addrLen), .addressBytes(addrBytes),
    .learningPatternVol(patV), .learningPatternNonvol(patN));
  flrc_host_model flrc_host_model_i (.serialClk(sck), .chipSelectN(csN), .ioIn(ioIn),
    .ioOut(ioOut), .ioOe(ioOe), .quad(quad));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic int e(input int b);
    return b * (quad ? 2 : 8);
  endfunction
  task automatic send(input logic [7:0] op, input logic [7:0] d, input int n);
    flrc_host_model_i.frame({op, d}, n, 0, rdv, oev);
    tick(6);
  endtask
  task automatic pulse(input int k);
    @(posedge clk) pulseV[k] <= 1'b1;
    @(posedge clk) pulseV <= 5'h00;
    tick(4);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // A hang shows up as a missing verdict, so the limit forces one.
  initial begin
    #300000;
    miscompares++;
    test_done();
  end

  initial begin
    {reset_n, quad, nvLen, nvFail, wideOnly} = 5'h00;
    pulseV = 5'h00;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    tick(4);
    check("status", st, 8'h0);
    check("addrBytes", addrBytes, 8'h3);
    send(OP_PATTERN_WRITE, 8'ha5, e(2));
    check("patNoWel", patV, 8'h00);
    send(OP_VOL_WRITE_ENABLE, 8'h00, e(1) - 1);
    check("volShort", toVol, 8'h0);
    send(OP_VOL_WRITE_ENABLE, 8'h00, e(1));
    check("volWel", write_enable_latch, 8'h0);
    check("toVol", toVol, 8'h1);
    pulse(4);
    check("toVolDone", toVol, 8'h0);
    send(OP_WRITE_ENABLE, 8'h00, e(1) + 1);
    check("welLong", write_enable_latch, 8'h0);
    send(OP_WRITE_ENABLE, 8'h00, e(1));
    check("welSet", write_enable_latch, 8'h1);
    send(OP_PATTERN_WRITE, 8'ha5, e(2) - 1);
    check("patShort", patV, 8'h00);
    send(OP_PATTERN_WRITE, 8'ha5, e(2));
    check("patVol", patV, 8'ha5);
    check("welKept", write_enable_latch, 8'h1);
    flrc_host_model_i.frame({OP_PATTERN_READ, 8'h00}, e(1), 16, rdv, oev);
    check("readData", rdv, 8'ha5);
    check("readOe", oev, 8'h2);
    send(OP_PATTERN_PROGRAM, 8'h3c, e(2));
    check("progBusy", st, 8'hc);
    tick(40);
    check("progDone", st, 8'h0);
    check("patNonvol", patN, 8'h3c);
    send(OP_PATTERN_PROGRAM, 8'h77, e(2));
    check("progNoWelBusy", write_in_progress, 8'h0);
    check("progNoWel", patN, 8'h3c);
    send(OP_WRITE_ENABLE, 8'h00, e(1));
    @(posedge clk) nvFail <= 1'b1;
    send(OP_PATTERN_PROGRAM, 8'h11, e(2));
    tick(40);
    check("progFail", {write_in_progress, pErr}, 8'h3);
    pulse(3);
    check("eraseErr", eErr, 8'h1);
    send(OP_CLEAR_STATUS, 8'h00, e(1) + 1);
    check("clrLong", pErr, 8'h1);
    send(OP_CLEAR_STATUS, 8'h00, e(1));
    check("clr", st, 8'h0);
    @(posedge clk) nvFail <= 1'b0;
    pulse(2);
    tick(30);
    check("regFail", {write_in_progress, pErr}, 8'h3);
    @(posedge clk) quad <= 1'b1;
    tick(2);
    send(OP_CLEAR_STATUS, 8'h00, e(1));
    check("clrQuad", st, 8'h0);
    send(OP_WRITE_ENABLE, 8'h00, e(1));
    send(OP_PATTERN_WRITE, 8'h5a, e(2));
    check("patQuad", patV, 8'h5a);
    flrc_host_model_i.frame({OP_PATTERN_READ, 8'h00}, e(1), 2, rdv, oev);
    check("readQuad", rdv, 8'h5a);
    check("readOeQuad", oev, 8'hf);
    @(posedge clk) quad <= 1'b0;
    tick(2);
    send(OP_ENTER_WIDE_ADDR, 8'h00, e(1));
    check("wideSet", {addrLen, addrBytes}, 8'hc);
    send(OP_EXIT_WIDE_ADDR, 8'h00, e(1));
    @(posedge clk) wideOnly <= 1'b1;
    tick(2);
    check("wideOnly", addrBytes, 8'h4);
    @(posedge clk) wideOnly <= 1'b0;
    tick(2);
    check("wideExit", {addrLen, addrBytes}, 8'h3);
    send(OP_ENTER_WIDE_ADDR, 8'h00, e(1));
    pulse(1);
    check("anyRegClr", addrLen, 8'h0);
    send(OP_ENTER_WIDE_ADDR, 8'h00, e(1));
    pulse(0);
    check("resetClr", addrLen, 8'h0);
    test_done();
  end
endmodule
`default_nettype wire
